/* File: hsc_defs.svh */
// offsets, field positions, reset values and counts of the halt standby controller
`ifndef HSC_DEFS_SVH
`define HSC_DEFS_SVH

// register byte offsets
`define HSC_OFS_CTRL      4'h0
`define HSC_OFS_STAT      4'h4
`define HSC_OFS_WCNT      4'h8

// control register fields
`define HSC_CTRL_CPU_SUB   0
`define HSC_CTRL_MAIN_OFF  1
`define HSC_CTRL_TMR8_EXT  2
`define HSC_CTRL_WATCH_SUB 3
`define HSC_CTRL_SIO_EXT   4
`define HSC_CTRL_IRQ0_MAIN 5
`define HSC_CTRL_DIV_LSB   8
`define HSC_CTRL_DIV_MSB   11
`define HSC_CTRL_RST       32'h0000_0020

// status register fields
`define HSC_STAT_STATE_LSB 0
`define HSC_STAT_SRC_LSB   2
`define HSC_STAT_VEC       5

// wake latencies in cpu clocks
`define HSC_VEC_CLKS      4'h8
`define HSC_NEXT_CLKS     4'h2

`endif

/* File: hsc_pkg.sv */
// types shared by the halt standby controller
`default_nettype none
package hsc_pkg;
   typedef enum logic [1:0] {HSC_RUN, HSC_HALT, HSC_WAKE} hsc_state_t;
   typedef enum logic [2:0] {
      HSC_SRC_NONE, HSC_SRC_IRQ, HSC_SRC_NMI, HSC_SRC_TEST, HSC_SRC_RESET
   } hsc_src_t;
endpackage
`default_nettype wire

/* File: hsc_halt_ctrl.sv */
// halt standby controller: cpu clock gating, wake-up and peripheral gating
`timescale 1ns/100ps
`include "hsc_defs.svh"
`default_nettype none

module hsc_halt_ctrl
   import hsc_pkg::*;
#(
   parameter int DIV_W = 4
) (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        halt_exec,
   input  wire logic        irq_req,
   input  wire logic        irq_mask,
   input  wire logic        irq_ack_en,
   input  wire logic        nmi_req,
   input  wire logic        test_req,
   input  wire logic        test_mask,
   input  wire logic        sub_clk_pin,
   output logic             cpu_clk_en,
   output logic             halted,
   output logic             vec_start,
   output logic             next_start,
   output logic             reset_start,
   output logic             tmr8_run_en,
   output logic             watch_run_en,
   output logic             sio_run_en,
   output logic             auto_sio_run_en,
   output logic             ext_irq_zero_en,
   output logic             ext_irq_others_en,
   input  wire logic [7:0]  cpu_ad_out,
   input  wire logic        cpu_ad_drive,
   input  wire logic [15:0] cpu_addr,
   input  wire logic        cpu_addr_latch_strobe,
   input  wire logic        cpu_rd_b,
   input  wire logic        cpu_wr_b,
   input  wire logic        cpu_wait_en,
   output logic      [7:0]  mux_addr_data_bus_o,
   output logic             mux_addr_data_bus_oe_b,
   output logic      [15:0] upper_addr_bus,
   output logic             addr_latch_strobe,
   output logic             rd_b,
   output logic             wr_b,
   output logic             wait_sense_en
);

   hsc_state_t        state_r;
   hsc_src_t          src_r;
   logic              vec_r;
   logic [3:0]        lat_cnt_r;
   logic [3:0]        lat_goal_r;
   logic [31:0]       ctrl_r;
   logic [15:0]       wake_cnt_r;
   logic [DIV_W-1:0]  div_cnt_r;
   logic              sub_s1_r;
   logic              sub_s2_r;
   logic              sub_s3_r;
   logic              ack_r;
   logic [31:0]       rdata_r;
   logic              vec_start_r;
   logic              next_start_r;
   logic              rst_done_r;
   logic [3:0]        wake_ticks_r;

   logic              irq_wake;
   logic              test_wake;
   logic              any_wake;
   logic              main_tick;
   logic              sub_tick;
   logic              cpu_tick;
   logic              in_halt;
   logic              halt_sub_stop;
   logic              bus_req;
   logic [DIV_W-1:0]  div_lim;

   // register decode shared by read mux and write path
   function automatic logic [1:0] reg_sel(input logic [3:0] addr);
      unique case (addr)
         `HSC_OFS_CTRL: reg_sel = 2'h1;
         `HSC_OFS_STAT: reg_sel = 2'h2;
         `HSC_OFS_WCNT: reg_sel = 2'h3;
         default:       reg_sel = 2'h0;
      endcase
   endfunction

   assign irq_wake  = irq_req & ~irq_mask;
   assign test_wake = test_req & ~test_mask;
   // masked sources leave halt untouched; nothing else is looked at
   assign any_wake  = nmi_req | irq_wake | test_wake;
   assign in_halt   = (state_r == HSC_HALT);
   assign halt_sub_stop = in_halt & ctrl_r[`HSC_CTRL_CPU_SUB]
                        & ctrl_r[`HSC_CTRL_MAIN_OFF];

   // sub clock pin, synchronised before its edge is used as a tick
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sub_s1_r <= 1'b0;
         sub_s2_r <= 1'b0;
         sub_s3_r <= 1'b0;
      end else begin
         sub_s1_r <= sub_clk_pin;
         sub_s2_r <= sub_s1_r;
         sub_s3_r <= sub_s2_r;
      end
   end
   assign sub_tick = sub_s2_r & ~sub_s3_r;

   // main divider; a stopped main oscillator gives no ticks
   assign div_lim = ctrl_r[`HSC_CTRL_DIV_LSB +: DIV_W];
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         div_cnt_r <= '0;
      end else if (div_cnt_r >= div_lim) begin
         div_cnt_r <= '0;
      end else begin
         div_cnt_r <= div_cnt_r + 1'b1;
      end
   end
   assign main_tick = (div_cnt_r >= div_lim)
                    & ~ctrl_r[`HSC_CTRL_MAIN_OFF];
   assign cpu_tick  = ctrl_r[`HSC_CTRL_CPU_SUB] ? sub_tick : main_tick;

   // the oscillators keep ticking; only the cpu enable is withheld
   assign cpu_clk_en = cpu_tick & ~in_halt;
   assign halted     = in_halt;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r    <= HSC_RUN;
         src_r      <= HSC_SRC_RESET;
         vec_r      <= 1'b0;
         lat_goal_r <= `HSC_NEXT_CLKS;
      end else begin
         unique case (state_r)
            HSC_RUN: begin
               if (halt_exec) begin
                  state_r <= HSC_HALT;
               end
            end
            HSC_HALT: begin
               // nmi outranks a maskable request, which outranks test
               if (nmi_req) begin
                  state_r    <= HSC_WAKE;
                  src_r      <= HSC_SRC_NMI;
                  vec_r      <= 1'b1;
                  lat_goal_r <= `HSC_VEC_CLKS;
               end else if (irq_wake) begin
                  state_r    <= HSC_WAKE;
                  src_r      <= HSC_SRC_IRQ;
                  vec_r      <= irq_ack_en;
                  lat_goal_r <= irq_ack_en ? `HSC_VEC_CLKS
                                           : `HSC_NEXT_CLKS;
               end else if (test_wake) begin
                  state_r    <= HSC_WAKE;
                  src_r      <= HSC_SRC_TEST;
                  vec_r      <= 1'b0;
                  lat_goal_r <= `HSC_NEXT_CLKS;
               end
            end
            HSC_WAKE: begin
               if (cpu_tick && (lat_cnt_r == lat_goal_r - 4'h1)) begin
                  state_r <= HSC_RUN;
               end
            end
         endcase
      end
   end

   // latency counted in cpu clocks, so it scales with the chosen clock
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         lat_cnt_r <= 4'h0;
      end else if (state_r != HSC_WAKE) begin
         lat_cnt_r <= 4'h0;
      end else if (cpu_tick) begin
         lat_cnt_r <= lat_cnt_r + 4'h1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         vec_start_r  <= 1'b0;
         next_start_r <= 1'b0;
      end else begin
         vec_start_r  <= (state_r == HSC_WAKE) & cpu_tick & vec_r
                       & (lat_cnt_r == lat_goal_r - 4'h1);
         next_start_r <= (state_r == HSC_WAKE) & cpu_tick & ~vec_r
                       & (lat_cnt_r == lat_goal_r - 4'h1);
      end
   end
   assign vec_start  = vec_start_r;
   assign next_start = next_start_r;

   // high from reset until the first clock after release; tells the cpu to fetch the reset vector
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_done_r <= 1'b0;
      end else begin
         rst_done_r <= 1'b1;
      end
   end
   assign reset_start = ~rst_done_r;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wake_cnt_r <= 16'h0000;
      end else if (in_halt && any_wake) begin
         wake_cnt_r <= wake_cnt_r + 16'h0001;
      end
   end

   // peripheral run enables, registered
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tmr8_run_en       <= 1'b1;
         watch_run_en      <= 1'b1;
         sio_run_en        <= 1'b1;
         auto_sio_run_en   <= 1'b1;
         ext_irq_zero_en   <= 1'b1;
         ext_irq_others_en <= 1'b1;
      end else begin
         tmr8_run_en     <= ~halt_sub_stop
                          | ctrl_r[`HSC_CTRL_TMR8_EXT];
         watch_run_en    <= ~halt_sub_stop
                          | ctrl_r[`HSC_CTRL_WATCH_SUB];
         sio_run_en      <= ~(in_halt & ctrl_r[`HSC_CTRL_MAIN_OFF])
                          | ctrl_r[`HSC_CTRL_SIO_EXT];
         auto_sio_run_en <= ~in_halt;
         // sampling for irq zero needs the main clock the cpu was on
         ext_irq_zero_en <= ~in_halt
                          | (ctrl_r[`HSC_CTRL_IRQ0_MAIN]
                             & ~ctrl_r[`HSC_CTRL_CPU_SUB]);
         ext_irq_others_en <= 1'b1;
      end
   end

   // expansion bus parks in halt; upper address keeps its last value
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mux_addr_data_bus_o    <= 8'h00;
         mux_addr_data_bus_oe_b <= 1'b1;
         upper_addr_bus         <= 16'h0000;
         addr_latch_strobe      <= 1'b0;
         rd_b                   <= 1'b1;
         wr_b                   <= 1'b1;
         wait_sense_en          <= 1'b0;
      end else if (in_halt) begin
         mux_addr_data_bus_oe_b <= 1'b1;
         addr_latch_strobe      <= 1'b0;
         rd_b                   <= 1'b1;
         wr_b                   <= 1'b1;
         wait_sense_en          <= 1'b0;
      end else begin
         mux_addr_data_bus_o    <= cpu_ad_out;
         mux_addr_data_bus_oe_b <= ~cpu_ad_drive;
         upper_addr_bus         <= cpu_addr;
         addr_latch_strobe      <= cpu_addr_latch_strobe;
         rd_b                   <= cpu_rd_b;
         wr_b                   <= cpu_wr_b;
         wait_sense_en          <= cpu_wait_en;
      end
   end

   // avalon slave: one wait cycle on every access, unmapped reads zero
   assign bus_req         = avs_read | avs_write;
   assign avs_waitrequest = bus_req & ~ack_r;
   assign avs_readdata    = rdata_r;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_r   <= 1'b0;
         rdata_r <= 32'h0000_0000;
      end else begin
         ack_r <= bus_req & ~ack_r;
         if (bus_req && !ack_r) begin
            unique case (reg_sel(avs_address))
               2'h1:    rdata_r <= ctrl_r;
               2'h2:    rdata_r <= {26'h0, vec_r, src_r, state_r};
               2'h3:    rdata_r <= {16'h0, wake_cnt_r};
               default: rdata_r <= 32'h0000_0000;
            endcase
         end
      end
   end

   // write lands on the edge where the master sees waitrequest low
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_r <= `HSC_CTRL_RST;
      end else if (avs_write && ack_r
                   && reg_sel(avs_address) == 2'h1) begin
         ctrl_r <= {20'h0, avs_writedata[11:0]};
      end
   end

   // helper for latency checks
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wake_ticks_r <= 4'h0;
      end else if (state_r != HSC_WAKE) begin
         wake_ticks_r <= 4'h0;
      end else if (cpu_tick && wake_ticks_r != 4'hf) begin
         wake_ticks_r <= wake_ticks_r + 4'h1;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   a_halt_entry: assert property (
      state_r == HSC_RUN && halt_exec |=> state_r == HSC_HALT)
      else $error("halt instruction did not enter halt");
   a_halt_gates_clk: assert property (
      in_halt |-> !cpu_clk_en)
      else $error("cpu clock enabled during halt");
   a_irq_wakes: assert property (
      in_halt && irq_wake |=> state_r == HSC_WAKE)
      else $error("unmasked request did not end halt");
   a_irq_vec_pick: assert property (
      in_halt && irq_wake && !nmi_req |=> vec_r == $past(irq_ack_en))
      else $error("vector choice ignores acknowledge enable");
   // the start pulses are held against a tick count kept apart from the
   // end compare, so a wrong goal or compare is caught
   a_vec_latency: assert property (
      vec_start
      |-> vec_r && wake_ticks_r inside {[4'h8:4'h9]})
      else $error("vectored wake latency out of range");
   a_next_latency: assert property (
      next_start
      |-> !vec_r && wake_ticks_r inside {[4'h2:4'h3]})
      else $error("resume latency out of range");
   a_nmi_vectored: assert property (
      in_halt && nmi_req |=> state_r == HSC_WAKE && vec_r)
      else $error("nmi wake not vectored");
   a_test_resume: assert property (
      in_halt && test_wake && !nmi_req && !irq_wake
      |=> state_r == HSC_WAKE && !vec_r)
      else $error("test wake took a vector");
   a_masked_hold: assert property (
      in_halt && !any_wake |=> in_halt)
      else $error("halt left without a wake source");
   a_reset_branch: assert property (
      reset_start |=> !reset_start && state_r == HSC_RUN)
      else $error("reset branch pulse malformed");
   a_tmr8_gate: assert property (
      halt_sub_stop && !ctrl_r[`HSC_CTRL_TMR8_EXT] |=> !tmr8_run_en)
      else $error("8-bit timer runs without pin clock");
   a_auto_sio_stop: assert property (
      in_halt |=> !auto_sio_run_en)
      else $error("automatic serial runs during halt");
   a_bus_parked: assert property (
      in_halt |=> mux_addr_data_bus_oe_b && !addr_latch_strobe
                  && rd_b && wr_b && !wait_sense_en
                  && $stable(upper_addr_bus))
      else $error("expansion bus not parked in halt");

endmodule
`default_nettype wire

/* File: hsc_cpu_model.sv */
// cpu core and interrupt controller model facing the halt controller
`timescale 1ns/100ps
`default_nettype none
module hsc_cpu_model (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        halt_cmd,
   input  wire logic        raise_irq,
   input  wire logic        raise_nmi,
   input  wire logic        drop_all,
   input  wire logic        vec_start,
   output logic             halt_exec,
   output logic             irq_req,
   output logic             nmi_req,
   output logic      [7:0]  cpu_ad_out,
   output logic             cpu_ad_drive,
   output logic      [15:0] cpu_addr,
   output logic             cpu_addr_latch_strobe,
   output logic             cpu_rd_b,
   output logic             cpu_wr_b,
   output logic             cpu_wait_en
);
   logic [15:0] pc_r;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         halt_exec <= 1'b0;
         irq_req   <= 1'b0;
         nmi_req   <= 1'b0;
         pc_r      <= 16'h0;
      end else begin
         halt_exec <= halt_cmd;
         pc_r      <= pc_r + 16'h1;
         // vectored service acknowledges and retires the pending request
         irq_req <= raise_irq | (irq_req & !drop_all & !vec_start);
         nmi_req <= raise_nmi | (nmi_req & !drop_all & !vec_start);
      end
   end
   // the bus keeps moving in halt, so only the controller can hold it
   assign cpu_addr     = pc_r;
   assign cpu_ad_out   = pc_r[7:0] ^ 8'h5a;
   assign cpu_ad_drive = pc_r[0];
   assign cpu_addr_latch_strobe     = pc_r[1];
   assign cpu_rd_b     = pc_r[2];
   assign cpu_wr_b     = ~pc_r[2];
   assign cpu_wait_en  = pc_r[3];
endmodule
`default_nettype wire

/* File: halt_standby_controller_bench.sv */
// self-checking bench of the halt standby controller
`timescale 1ns/100ps
`include "hsc_defs.svh"
`default_nettype none
module halt_standby_controller_bench import hsc_pkg::*;;
   logic        core_clk = 0, rst_b = 0, avs_read = 0, avs_write = 0;
   logic [3:0]  avs_address = '0;
   logic [31:0] avs_writedata = '0, avs_readdata, rd_v, ctl;
   logic        avs_waitrequest, halt_exec, irq_req, nmi_req;
   logic        irq_mask = 1, irq_ack_en = 0, test_req = 0, test_mask = 1;
   logic        sub_clk_pin = 0, cpu_clk_en, halted, vec_start, next_start;
   logic        reset_start, tmr8_run_en, watch_run_en, sio_run_en;
   logic        auto_sio_run_en, ext_irq_zero_en, ext_irq_others_en;
   logic [7:0]  cpu_ad_out, mux_addr_data_bus_o, held_ad;
   logic        cpu_ad_drive, cpu_addr_latch_strobe, cpu_rd_b, cpu_wr_b, cpu_wait_en;
   logic [15:0] cpu_addr, upper_addr_bus, held;
   logic        mux_addr_data_bus_oe_b, addr_latch_strobe, rd_b, wr_b;
   logic        wait_sense_en, halt_cmd = 0, raise_irq = 0, raise_nmi = 0;
   logic        drop_all = 0, n, i, im, ae, t, tm;
   logic [3:0]  ex;
   int          fail_count = 0, n_tests = 0, wakes = 0, kind;

   hsc_halt_ctrl #(.DIV_W(4)) dut (
      .core_clk, .rst_b, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_readdata, .avs_waitrequest, .halt_exec,
      .irq_req, .irq_mask, .irq_ack_en, .nmi_req, .test_req, .test_mask,
      .sub_clk_pin, .cpu_clk_en, .halted, .vec_start, .next_start,
      .reset_start, .tmr8_run_en, .watch_run_en, .sio_run_en,
      .auto_sio_run_en, .ext_irq_zero_en, .ext_irq_others_en,
      .cpu_ad_out, .cpu_ad_drive, .cpu_addr, .cpu_addr_latch_strobe, .cpu_rd_b,
      .cpu_wr_b, .cpu_wait_en, .mux_addr_data_bus_o,
      .mux_addr_data_bus_oe_b, .upper_addr_bus, .addr_latch_strobe,
      .rd_b, .wr_b, .wait_sense_en
   );
   hsc_cpu_model cpu (
      .core_clk, .rst_b, .halt_cmd, .raise_irq, .raise_nmi, .drop_all,
      .vec_start, .halt_exec, .irq_req, .nmi_req, .cpu_ad_out,
      .cpu_ad_drive, .cpu_addr, .cpu_addr_latch_strobe, .cpu_rd_b, .cpu_wr_b,
      .cpu_wait_en
   );

   always #2 core_clk = ~core_clk;
   // sub clock pin far slower than the core clock, free running
   always begin
      repeat (5) @(posedge core_clk);
      sub_clk_pin <= ~sub_clk_pin;
   end

   task automatic chk(input string nm, input logic [31:0] e, s);
      n_tests++;
      if (s !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] d);
      @(posedge core_clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      rd_v = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask
   function automatic logic [3:0] exp_wake(logic n, i, im, ae, t, tm);
      if (n) return {1'b1, HSC_SRC_NMI};
      if (i && !im) return {ae, HSC_SRC_IRQ};
      if (t && !tm) return {1'b0, HSC_SRC_TEST};
      return {1'b0, HSC_SRC_NONE};
   endfunction
   task automatic go_halt();
      @(posedge core_clk);
      halt_cmd <= 1'b1;
      @(posedge core_clk);
      halt_cmd <= 1'b0;
      repeat (4) @(posedge core_clk);
      #1;
      chk("halted", 1, halted);
      chk("clk gated", 0, cpu_clk_en);
      chk("ad float", 1, mux_addr_data_bus_oe_b);
      chk("addr_latch_strobe", 0, addr_latch_strobe);
      chk("strobes", 2'b11, {rd_b, wr_b});
      chk("wait pin", 0, wait_sense_en);
      chk("auto sio", 0, auto_sio_run_en);
      held = upper_addr_bus;
      held_ad = mux_addr_data_bus_o;
      repeat (3) @(posedge core_clk);
      #1;
      chk("addr hold", held, upper_addr_bus);
      chk("ad hold", held_ad, mux_addr_data_bus_o);
   endtask
   // counts cpu ticks between leaving halt and the start pulse
   task automatic wait_wake(input int ex_ticks, input logic ex_vec);
      int c;
      c = 0;
      forever begin
         @(posedge core_clk);
         #1;
         if (vec_start | next_start) break;
         if (!halted && cpu_clk_en) c++;
      end
      chk("wake ticks", ex_ticks, c);
      chk("vectored", ex_vec, vec_start);
   endtask
   task automatic drop();
      @(posedge core_clk);
      drop_all  <= 1'b1;
      test_req  <= 1'b0;
      irq_mask  <= 1'b1;
      test_mask <= 1'b1;
      @(posedge core_clk);
      drop_all <= 1'b0;
      wakes++;
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      close_out();
   end

   initial begin
      void'($urandom(32'h464ce86a));
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      bus(0, `HSC_OFS_CTRL, '0);
      chk("ctrl reset", `HSC_CTRL_RST, rd_v);
      bus(1, `HSC_OFS_CTRL, 32'hffff_ffff);
      bus(0, `HSC_OFS_CTRL, '0);
      chk("ctrl width", 32'h0000_0fff, rd_v);
      bus(0, `HSC_OFS_STAT, '0);
      ctl = rd_v;
      bus(1, `HSC_OFS_STAT, ~ctl);
      bus(0, `HSC_OFS_STAT, '0);
      chk("stat ro", ctl, rd_v);
      bus(0, 4'hc, '0);
      chk("unmapped", 32'h0, rd_v);
      bus(1, `HSC_OFS_CTRL, `HSC_CTRL_RST);
      $display("test registers done");
      // masked sources must leave the core asleep
      go_halt();
      @(posedge core_clk);
      raise_irq <= 1'b1;
      test_req  <= 1'b1;
      @(posedge core_clk);
      raise_irq <= 1'b0;
      repeat (30) @(posedge core_clk);
      #1;
      chk("masked hold", 1, halted);
      @(posedge core_clk);
      irq_mask <= 1'b0;
      wait_wake(2, 0);
      drop();
      $display("test masked wake done");
      for (int k = 0; k < 2; k++) begin
         // second pass flips every gate bit so both settings are seen
         ctl = k ? {ctl[31:6], ~ctl[5:2], ctl[1:0]}
                 : {26'h0, 4'($urandom), 2'b11};
         bus(1, `HSC_OFS_CTRL, ctl);
         go_halt();
         chk("tmr8 sub", ctl[2], tmr8_run_en);
         chk("watch sub", ctl[3], watch_run_en);
         chk("sio sub", ctl[4], sio_run_en);
         chk("irq0 sub", 0, ext_irq_zero_en);
         chk("irq others", 1, ext_irq_others_en);
         @(posedge core_clk);
         raise_nmi <= 1'b1;
         @(posedge core_clk);
         raise_nmi <= 1'b0;
         wait_wake(8, 1);
         drop();
      end
      $display("test sub clock halt done");
      for (int k = 0; k < 12; k++) begin
         kind = k % 3;
         ctl = {20'h0, 4'($urandom_range(0, 3)), 2'b00, 1'($urandom), 5'h0};
         bus(1, `HSC_OFS_CTRL, ctl);
         go_halt();
         chk("irq0 main", ctl[5], ext_irq_zero_en);
         chk("tmr8 main", 1, tmr8_run_en);
         n  = (kind == 0);
         i  = (kind == 1) | 1'($urandom);
         im = (kind == 2) | ((kind == 0) & 1'($urandom));
         t  = (kind == 2) | 1'($urandom);
         tm = (kind == 1) & 1'($urandom);
         ae = 1'($urandom);
         ex = exp_wake(n, i, im, ae, t, tm);
         @(posedge core_clk);
         irq_mask   <= im;
         test_mask  <= tm;
         irq_ack_en <= ae;
         raise_nmi  <= n;
         raise_irq  <= i;
         // test input delayed so all sources reach the block together
         @(posedge core_clk);
         raise_nmi <= 1'b0;
         raise_irq <= 1'b0;
         test_req  <= t;
         wait_wake(ex[3] ? 8 : 2, ex[3]);
         bus(0, `HSC_OFS_STAT, '0);
         chk("stat", {26'h0, ex, 2'b00}, rd_v);
         drop();
      end
      $display("test random wakes done");
      bus(0, `HSC_OFS_WCNT, '0);
      chk("wake count", wakes, {16'h0, rd_v[15:0]});
      go_halt();
      @(posedge core_clk);
      rst_b <= 1'b0;
      #1;
      chk("rst halted", 0, halted);
      chk("rst start", 1, reset_start);
      @(posedge core_clk);
      rst_b <= 1'b1;
      #1;
      chk("rst first", 1, reset_start);
      @(posedge core_clk);
      #1;
      chk("rst done", 0, reset_start);
      bus(0, `HSC_OFS_STAT, '0);
      chk("rst src", {26'h0, 1'b0, HSC_SRC_RESET, HSC_RUN}, rd_v);
      $display("test reset wake done");
      close_out();
   end
endmodule
`default_nettype wire
